// ===== rtl/dcc_calibrator.sv
`timescale 1ns/1ns
`include "dcc_cfg.svh"

// How it works
// - Forty channels in four groups of ten all share one calibration datapath.
// - Each channel has its own input, converter, gain and offset registers.
// - The code is (gain+1) times input over 2^13, plus offset minus 2^13.
// - The 14-bit input-code register resets to midscale 0x2000.
// - The 13-bit gain register resets to all ones.
// - The 14-bit offset register resets to 0x2000.
// - The computed converter-code register resets to midscale 0x2000.
// - Out-of-range results clamp to full scale or zero instead of wrapping.
// - The converter register is 14-bit straight binary and alone sets the output.
// - Writing one channel's gain or offset leaves every other channel untouched.
// - Any write to input, gain or offset recomputes that channel with busy low meanwhile.
// - A load copies a computed code only into channels written since the last load.
// - Reset returns all input, gain, offset and computed registers to their defaults.
module dcc_calibrator
    import dcc_pkg::*;
#(
    parameter int CHANNELS = `DCC_CHANNELS,
    parameter int GROUPS = `DCC_GROUPS,
    parameter int GROUP_SIZE = `DCC_GROUP_SIZE
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Host write port
    input wire logic wrEn,
    input wire dcc_sel_type wrSel,
    input wire dcc_chan_type wrChan,
    input wire dcc_code_type wrData,
    // Host read port
    input wire dcc_sel_type rdSel,
    input wire dcc_chan_type rdChan,
    output dcc_code_type rdData,
    // Load and status
    input wire logic output_load_strobe_n,
    output logic busy_n,
    // Converter codes
    output dcc_code_type [CHANNELS-1:0] dacCodes
);
    if (CHANNELS != GROUPS * GROUP_SIZE || CHANNELS > (1 << `DCC_CHAN_W)
        || CHANNELS < 1) begin : gBadSize
        $error("Channel count must equal groups times group size and fit the index.");
    end

    dcc_calc_if calc ();

    dcc_code_type inputReg [CHANNELS];
    dcc_code_type inputNext [CHANNELS];
    dcc_gain_type gainReg [CHANNELS];
    dcc_gain_type gainNext [CHANNELS];
    dcc_code_type offsetReg [CHANNELS];
    dcc_code_type offsetNext [CHANNELS];
    dcc_code_type convReg [CHANNELS];
    dcc_code_type convNext [CHANNELS];
    dcc_code_type [CHANNELS-1:0] dacNext;
    logic [CHANNELS-1:0] pendReg;
    logic [CHANNELS-1:0] pendNext;
    logic [CHANNELS-1:0] changedReg;
    logic [CHANNELS-1:0] changedNext;
    logic loadPendReg;
    logic loadPendNext;
    logic loadFire;
    logic busyNext;
    dcc_code_type rdDataNext;
    dcc_state_type stateReg;
    dcc_state_type stateNext;
    dcc_chan_type pickChan;
    logic pickFound;

    // Lowest pending channel first, so a burst drains in a fixed order.
    function automatic dcc_chan_type firstPend(input logic [CHANNELS-1:0] p);
        firstPend = '0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (p[i]) begin
                firstPend = dcc_chan_type'(i);
            end
        end
    endfunction

    dcc_calc_unit calcUnit (
        .mclk(mclk),
        .rst_b(rst_b),
        .calc(calc.worker)
    );

    always_comb begin
        pickFound = |pendReg;
        pickChan = firstPend(pendReg);
    end

    // One shared datapath serves every channel in turn.
    assign calc.reqValid = (stateReg == CALC_IDLE) && pickFound;
    assign calc.reqChan = pickChan;
    assign calc.reqInput = inputReg[pickChan];
    assign calc.reqGain = gainReg[pickChan];
    assign calc.reqOffset = offsetReg[pickChan];

    always_comb begin
        inputNext = inputReg;
        gainNext = gainReg;
        offsetNext = offsetReg;
        convNext = convReg;
        dacNext = dacCodes;
        pendNext = pendReg;
        changedNext = changedReg;
        stateNext = stateReg;
        rdDataNext = rdData;
        case (stateReg)
            CALC_IDLE: begin
                if (pickFound) begin
                    pendNext[pickChan] = 1'b0;
                    stateNext = CALC_WAIT;
                end
            end
            CALC_WAIT: begin
                if (calc.respValid) begin
                    stateNext = CALC_IDLE;
                end
            end
            default: begin
                stateNext = CALC_IDLE;
            end
        endcase
        // A load copies only codes recomputed since the previous load.
        loadFire = loadPendReg && busy_n;
        if (loadFire) begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (changedReg[i]) begin
                    dacNext[i] = convReg[i];
                    changedNext[i] = 1'b0;
                end
            end
        end
        // Results land after the load so a fresh code is never lost.
        if (calc.respValid) begin
            convNext[calc.respChan] = calc.respCode;
            changedNext[calc.respChan] = 1'b1;
        end
        // A write after the issue clear re-arms the channel: set wins.
        if (wrEn && wrChan < CHANNELS && wrSel != `DCC_SEL_CONV) begin
            pendNext[wrChan] = 1'b1;
            case (wrSel)
                `DCC_SEL_INPUT: inputNext[wrChan] = wrData;
                `DCC_SEL_GAIN: gainNext[wrChan] = wrData[`DCC_GAIN_W-1:0];
                `DCC_SEL_OFFSET: offsetNext[wrChan] = wrData;
                default: ;
            endcase
        end
        // Stored while busy and honoured once the calculations finish.
        loadPendNext = !output_load_strobe_n || (loadPendReg && !loadFire);
        busyNext = !(|pendNext) && (stateNext == CALC_IDLE);
        if (rdChan < CHANNELS) begin
            case (rdSel)
                `DCC_SEL_INPUT: rdDataNext = inputReg[rdChan];
                `DCC_SEL_GAIN: rdDataNext = {1'b0, gainReg[rdChan]};
                `DCC_SEL_OFFSET: rdDataNext = offsetReg[rdChan];
                default: rdDataNext = convReg[rdChan];
            endcase
        end else begin
            rdDataNext = `DCC_ZERO_CODE;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < CHANNELS; i++) begin
                inputReg[i] <= `DCC_MID_CODE;
                gainReg[i] <= `DCC_GAIN_RST;
                offsetReg[i] <= `DCC_OFFS_RST;
                convReg[i] <= `DCC_MID_CODE;
                dacCodes[i] <= `DCC_MID_CODE;
            end
            pendReg <= '0;
            changedReg <= '0;
            loadPendReg <= 1'b0;
            busy_n <= 1'b1;
            rdData <= `DCC_ZERO_CODE;
            stateReg <= CALC_IDLE;
        end else begin
            inputReg <= inputNext;
            gainReg <= gainNext;
            offsetReg <= offsetNext;
            convReg <= convNext;
            dacCodes <= dacNext;
            pendReg <= pendNext;
            changedReg <= changedNext;
            loadPendReg <= loadPendNext;
            busy_n <= busyNext;
            rdData <= rdDataNext;
            stateReg <= stateNext;
        end
    end

    sequence writeSeq;
        wrEn && wrChan < CHANNELS && wrSel != `DCC_SEL_CONV;
    endsequence

    sequence busyThenDone;
        !busy_n [*2] ##[0:200] busy_n;
    endsequence

    write_busy_a: assert property (@(posedge mclk) disable iff (!rst_b)
        writeSeq |=> busyThenDone)
        else $error("Write did not produce a bounded busy pulse.");
    gain_store_a: assert property (@(posedge mclk) disable iff (!rst_b)
        writeSeq and (wrSel == `DCC_SEL_GAIN)
        |=> gainReg[$past(wrChan)] == $past(wrData[`DCC_GAIN_W-1:0]))
        else $error("Gain write not stored.");
    other_chan_a: assert property (@(posedge mclk) disable iff (!rst_b)
        wrEn && wrChan != '0 |=> gainReg[0] == $past(gainReg[0])
        && offsetReg[0] == $past(offsetReg[0]))
        else $error("Write to another channel disturbed channel zero.");
    load_copy_a: assert property (@(posedge mclk) disable iff (!rst_b)
        loadFire && changedReg[0] |=> dacCodes[0] == $past(convReg[0]) && !changedReg[0])
        else $error("Changed code not loaded.");
    load_skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !(loadFire && changedReg[0]) |=> $stable(dacCodes[0]))
        else $error("Converter register changed without a load of fresh data.");
    busy_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !busy_n |=> $stable(dacCodes))
        else $error("Outputs updated while busy.");
    load_wait_a: assert property (@(posedge mclk) disable iff (!rst_b)
        loadPendReg && !busy_n |=> loadPendReg)
        else $error("Load during busy was not stored.");
    load_latch_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !output_load_strobe_n |=> loadPendReg)
        else $error("Load strobe was not latched.");
    result_store_a: assert property (@(posedge mclk) disable iff (!rst_b)
        calc.respValid |=> convReg[$past(calc.respChan)] == $past(calc.respCode)
        && changedReg[$past(calc.respChan)])
        else $error("Computed code not stored.");
endmodule

// ===== shared/dcc_cfg.svh
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

`define DCC_CHANNELS 40
`define DCC_GROUPS 4
`define DCC_GROUP_SIZE 10
`define DCC_CHAN_W 6
`define DCC_CODE_W 14
`define DCC_GAIN_W 13
`define DCC_PROD_W 28
`define DCC_RAW_W 17
`define DCC_SHIFT 13
`define DCC_MID_CODE 14'h2000
`define DCC_GAIN_RST 13'h1fff
`define DCC_OFFS_RST 14'h2000
`define DCC_FULL_CODE 14'h3fff
`define DCC_ZERO_CODE 14'h0000
`define DCC_HALF_RAW 17'h0_2000
`define DCC_FULL_RAW 17'h0_3fff
`define DCC_GAIN_ONE 14'h0001
`define DCC_SEL_INPUT 2'h0
`define DCC_SEL_GAIN 2'h1
`define DCC_SEL_OFFSET 2'h2
`define DCC_SEL_CONV 2'h3

`endif

// ===== shared/dcc_pkg.sv
`include "dcc_cfg.svh"

package dcc_pkg;
    typedef logic [`DCC_CODE_W-1:0] dcc_code_type;
    typedef logic [`DCC_GAIN_W-1:0] dcc_gain_type;
    typedef logic [`DCC_CHAN_W-1:0] dcc_chan_type;
    typedef logic [1:0] dcc_sel_type;
    typedef logic signed [`DCC_RAW_W-1:0] dcc_raw_type;
    typedef enum logic {CALC_IDLE, CALC_WAIT} dcc_state_type;
endpackage

// ===== shared/dcc_calc_if.sv
`timescale 1ns/1ns

interface dcc_calc_if;
    import dcc_pkg::*;
    logic reqValid;
    dcc_chan_type reqChan;
    dcc_code_type reqInput;
    dcc_gain_type reqGain;
    dcc_code_type reqOffset;
    logic respValid;
    dcc_chan_type respChan;
    dcc_code_type respCode;
    modport issuer (
        output reqValid, reqChan, reqInput, reqGain, reqOffset,
        input respValid, respChan, respCode
    );
    modport worker (
        input reqValid, reqChan, reqInput, reqGain, reqOffset,
        output respValid, respChan, respCode
    );
endinterface

// ===== rtl/dcc_calc_unit.sv
`timescale 1ns/1ns
`include "dcc_cfg.svh"

module dcc_calc_unit
    import dcc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Calculation port
    dcc_calc_if.worker calc
);
    logic validReg;
    logic validNext;
    dcc_chan_type chanReg;
    dcc_chan_type chanNext;
    dcc_code_type codeReg;
    dcc_code_type codeNext;
    dcc_raw_type rawValue;

    // Kept signed and wide so that the clamp sees the exact result.
    function automatic dcc_raw_type calcRaw(input dcc_code_type inCode,
                                            input dcc_gain_type gain,
                                            input dcc_code_type offs);
        logic [`DCC_CODE_W-1:0] gainPlus;
        logic [`DCC_PROD_W-1:0] prod;
        logic [`DCC_CODE_W:0] scaled;
        gainPlus = {1'b0, gain} + `DCC_GAIN_ONE;
        prod = gainPlus * inCode;
        scaled = prod[`DCC_PROD_W-1:`DCC_SHIFT];
        calcRaw = $signed({2'b00, scaled}) + $signed({3'b000, offs})
                  - $signed(`DCC_HALF_RAW);
    endfunction

    function automatic dcc_code_type clampRaw(input dcc_raw_type raw);
        if (raw < 0) begin
            clampRaw = `DCC_ZERO_CODE;
        end else if (raw > $signed(`DCC_FULL_RAW)) begin
            clampRaw = `DCC_FULL_CODE;
        end else begin
            clampRaw = raw[`DCC_CODE_W-1:0];
        end
    endfunction

    always_comb begin
        rawValue = calcRaw(calc.reqInput, calc.reqGain, calc.reqOffset);
        validNext = calc.reqValid;
        chanNext = calc.reqChan;
        codeNext = calc.reqValid ? clampRaw(rawValue) : codeReg;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            validReg <= 1'b0;
            chanReg <= '0;
            codeReg <= `DCC_MID_CODE;
        end else begin
            validReg <= validNext;
            chanReg <= chanNext;
            codeReg <= codeNext;
        end
    end

    assign calc.respValid = validReg;
    assign calc.respChan = chanReg;
    assign calc.respCode = codeReg;

    clamp_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
        calc.reqValid && rawValue > $signed(`DCC_FULL_RAW) |=> calc.respCode == `DCC_FULL_CODE)
        else $error("Overflow not clamped to full scale.");
    clamp_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
        calc.reqValid && rawValue < 0 |=> calc.respCode == `DCC_ZERO_CODE)
        else $error("Underflow not clamped to zero.");
    calc_result_a: assert property (@(posedge mclk) disable iff (!rst_b)
        calc.reqValid && rawValue >= 0 && rawValue <= $signed(`DCC_FULL_RAW)
        |=> calc.respValid && calc.respCode == $past(rawValue[`DCC_CODE_W-1:0]))
        else $error("In-range result differs from the transfer function.");
endmodule

// ===== sim/dcc_host_model.sv
`timescale 1ns/1ns

module dcc_host_model
    import dcc_pkg::*;
(
    // Clock and read data
    input wire logic mclk,
    input wire dcc_code_type rdData,
    // Host write port
    output logic wrEn,
    output dcc_sel_type wrSel,
    output dcc_chan_type wrChan,
    output dcc_code_type wrData,
    // Host read port
    output dcc_sel_type rdSel,
    output dcc_chan_type rdChan,
    // Load strobe
    output logic output_load_strobe_n
);
    initial begin
        wrEn = 1'b0;
        wrSel = 2'h0;
        wrChan = 6'h00;
        wrData = 14'h0000;
        rdSel = 2'h0;
        rdChan = 6'h00;
        output_load_strobe_n = 1'b1;
    end

    // One word per write, addressed to a single channel only.
    task automatic wr(input dcc_sel_type s, input dcc_chan_type c, input dcc_code_type d);
        wrEn = 1'b1;
        wrSel = s;
        wrChan = c;
        wrData = d;
        @(posedge mclk);
        #1;
        wrEn = 1'b0;
        // An idle edge keeps the next call from raising the strobe in this step.
        @(posedge mclk);
        #1;
    endtask

    // Leaves the strobe high so that the next call continues a burst.
    task automatic wrHold(input dcc_sel_type s, input dcc_chan_type c, input dcc_code_type d);
        wrEn = 1'b1;
        wrSel = s;
        wrChan = c;
        wrData = d;
        @(posedge mclk);
        #1;
    endtask

    // The answer is registered, so it is taken one edge after the request.
    task automatic rd(input dcc_sel_type s, input dcc_chan_type c, output dcc_code_type q);
        rdSel = s;
        rdChan = c;
        @(posedge mclk);
        #1;
        q = rdData;
    endtask

    task automatic load();
        output_load_strobe_n = 1'b0;
        @(posedge mclk);
        #1;
        output_load_strobe_n = 1'b1;
    endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ns

module tb_top
    import dcc_pkg::*;
;
    logic mclk;
    logic rst_b;
    logic wrEn;
    dcc_sel_type wrSel;
    dcc_chan_type wrChan;
    dcc_code_type wrData;
    dcc_sel_type rdSel;
    dcc_chan_type rdChan;
    dcc_code_type rdData;
    logic ldN;
    logic busy_n;
    dcc_code_type [39:0] dacCodes;
    int failures = 0;
    int comparisons = 0;
    dcc_code_type q;
    dcc_code_type resetVal [4] = '{14'h2000, 14'h1fff, 14'h2000, 14'h2000};
    dcc_code_type tx [4] = '{14'h3000, 14'h3fff, 14'h3fff, 14'h1000};
    dcc_code_type tg [4] = '{14'h1fff, 14'h0fff, 14'h1fff, 14'h1fff};
    dcc_code_type tc [4] = '{14'h2000, 14'h2000, 14'h3fff, 14'h0000};

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    dcc_calibrator dut (.mclk(mclk), .rst_b(rst_b), .wrEn(wrEn), .wrSel(wrSel),
        .wrChan(wrChan), .wrData(wrData), .rdSel(rdSel), .rdChan(rdChan), .rdData(rdData),
        .output_load_strobe_n(ldN), .busy_n(busy_n), .dacCodes(dacCodes));

    dcc_host_model host (.mclk(mclk), .rdData(rdData), .wrEn(wrEn), .wrSel(wrSel),
        .wrChan(wrChan), .wrData(wrData), .rdSel(rdSel), .rdChan(rdChan),
        .output_load_strobe_n(ldN));

    // Signed wide arithmetic so the clamp sees the true sum, not a wrapped one.
    function automatic dcc_code_type calc(dcc_code_type x, dcc_code_type g, dcc_code_type c);
        longint p;
        p = (((longint'(g) + 1) * longint'(x)) >>> 13) + longint'(c) - 8192;
        if (p < 0) return 14'h0000;
        if (p > 16383) return 14'h3fff;
        return dcc_code_type'(p);
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input dcc_code_type got, input dcc_code_type exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for busy_n high, then lets a pending load land.
    task automatic settle();
        int n;
        n = 0;
        while (busy_n !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 200) begin
                failures++;
                $display("mismatch at %0t: got %h expected %h", $time, busy_n, 1'b1);
                tally_and_finish();
            end
        end
        repeat (3) @(posedge mclk);
        #1;
    endtask

    initial begin
        rst_b = 1'b0;
        repeat (10) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        for (int s = 0; s < 4; s++) begin
            host.rd(dcc_sel_type'(s), 6'd0, q);
            chk(q, resetVal[s]);
            host.rd(dcc_sel_type'(s), 6'd39, q);
            chk(q, resetVal[s]);
        end
        chk(dacCodes[39], 14'h2000);
        for (int i = 0; i < 4; i++) begin
            host.wr(2'h0, 6'd5, tx[i]);
            chk(dcc_code_type'(busy_n), 14'h0000);
            host.wr(2'h1, 6'd5, tg[i]);
            host.wr(2'h2, 6'd5, tc[i]);
            settle();
            host.rd(2'h3, 6'd5, q);
            chk(q, calc(tx[i], tg[i], tc[i]));
        end
        host.rd(2'h1, 6'd4, q);
        chk(q, 14'h1fff);
        host.rd(2'h2, 6'd6, q);
        chk(q, 14'h2000);
        chk(dacCodes[5], 14'h2000);
        host.load();
        settle();
        chk(dacCodes[5], calc(tx[3], tg[3], tc[3]));
        chk(dacCodes[4], 14'h2000);
        // Back-to-back writes across all four groups while busy is low.
        host.wrHold(2'h0, 6'd0, 14'h0080);
        for (int i = 0; i < 3; i++) begin
            host.wrHold(2'h0, dcc_chan_type'(i * 10 + 9), 14'h0100 * (i + 1));
        end
        host.wr(2'h0, 6'd39, 14'h0400);
        host.load();
        settle();
        for (int i = 0; i < 4; i++) begin
            chk(dacCodes[i * 10 + 9], 14'h0100 * (i + 1));
        end
        chk(dacCodes[0], 14'h0080);
        chk(dacCodes[5], calc(tx[3], tg[3], tc[3]));
        host.wr(2'h3, 6'd5, 14'h0000);
        host.wr(2'h0, 6'd40, 14'h0000);
        settle();
        host.rd(2'h0, 6'd5, q);
        chk(q, tx[3]);
        host.rd(2'h0, 6'd40, q);
        chk(q, 14'h0000);
        rst_b = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        host.rd(2'h0, 6'd5, q);
        chk(q, 14'h2000);
        host.rd(2'h1, 6'd5, q);
        chk(q, 14'h1fff);
        chk(dacCodes[19], 14'h2000);
        tally_and_finish();
    end
endmodule
